// [core/sam_device.sv]
/*
 Converter end: select filter, eight-cycle exchange, sampling, approximation and decode.
 Assumes every link signal is asynchronous to clock and far slower than it.
*/
`timescale 1ns/100ps
module sam_device #(
   parameter int CONV_CYCLES = sam_pkg::CONV_CYCLES_DEF,
   parameter int SAMPLE_CYCLES = sam_pkg::SAMPLE_CYCLES
) (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Link
   sam_if.dev link,
   // Analog levels, input n in bits n*8+7 to n*8
   input wire logic [sam_pkg::NUM_INPUTS*8-1:0] analog_levels,
   // Status
   output logic [4:0] channel_code,
   output sam_pkg::sam_sel_t channel_kind,
   output logic sampling,
   output logic converting,
   output logic result_valid,
   // Logic test outputs on inputs 0 to 4
   output logic [4:0] test_out,
   output logic [4:0] test_out_oe
);

   ////////////////////////////////////////////////////////////////////////////////
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic sclk_d;
   logic conv_d;
   logic cs_filt;
   logic cs_filt_d;
   logic [1:0] flt_cnt;
   sam_pkg::sam_dev_state_t state;
   logic [3:0] rise_cnt;
   logic [3:0] fall_cnt;
   logic [7:0] addr;
   logic [7:0] shift;
   logic [7:0] result;
   logic result_ok;
   logic [5:0] conv_cnt;
   logic [8:0] samp_cnt;
   logic [7:0] held;
   logic [7:0] approx;
   logic [7:0] mask;
   logic [7:0] trial;
   logic cs_raw;
   logic sdi_s;
   logic sclk_s;
   logic conv_s;
   logic sclk_rise;
   logic sclk_fall;
   logic conv_rise;
   logic filt_fall;
   logic filt_rise;
   logic last_fall;
   logic capture;
   logic conv_done;

   assign cs_raw = sync_b[0];
   assign sdi_s = sync_b[1];
   assign sclk_s = sync_b[2];
   assign conv_s = sync_b[3];
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign conv_rise = conv_s & ~conv_d;
   assign filt_fall = cs_filt_d & ~cs_filt;
   assign filt_rise = ~cs_filt_d & cs_filt;
   assign last_fall = (state == sam_pkg::SAM_DEV_XFER) && sclk_fall
                      && (fall_cnt < rise_cnt) && (fall_cnt == 4'(sam_pkg::EXCHANGE_BITS - 1));
   assign capture = (state == sam_pkg::SAM_DEV_CONV) && (samp_cnt == 9'(SAMPLE_CYCLES - 1));
   assign conv_done = (state == sam_pkg::SAM_DEV_CONV) && conv_rise
                      && (conv_cnt == 6'(CONV_CYCLES - 1));
   assign trial = approx | mask;

   // Only the second stage is ever read.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_a <= sam_pkg::SYNC_RESET;
         sync_b <= sam_pkg::SYNC_RESET;
         sclk_d <= 1'b0;
         conv_d <= 1'b0;
      end else begin
         sync_a <= {link.conv_clk, link.sclk, link.sdi, link.cs_n};
         sync_b <= sync_a;
         sclk_d <= sclk_s;
         conv_d <= conv_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Select must survive two conversion clock rises before it counts, so a pulse
   // shorter than one period never reaches the sequencer.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cs_filt <= 1'b1;
         cs_filt_d <= 1'b1;
         flt_cnt <= 2'h0;
      end else begin
         cs_filt_d <= cs_filt;
         if (cs_raw == cs_filt) begin
            flt_cnt <= 2'h0;
         end else if (conv_rise) begin
            if (flt_cnt == 2'(sam_pkg::CS_FILTER_EDGES - 1)) begin
               cs_filt <= cs_raw;
               flt_cnt <= 2'h0;
            end else begin
               flt_cnt <= flt_cnt + 2'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= sam_pkg::SAM_DEV_IDLE;
      end else begin
         case (state)
            sam_pkg::SAM_DEV_IDLE: begin
               if (!cs_filt) begin
                  state <= sam_pkg::SAM_DEV_XFER;
               end
            end
            sam_pkg::SAM_DEV_XFER: begin
               if (filt_rise) begin
                  state <= sam_pkg::SAM_DEV_IDLE;
               end else if (last_fall) begin
                  state <= sam_pkg::SAM_DEV_CONV;
               end
            end
            sam_pkg::SAM_DEV_CONV: begin
               if (filt_fall || conv_done) begin
                  state <= sam_pkg::SAM_DEV_IDLE;
               end
            end
            default: begin
               state <= sam_pkg::SAM_DEV_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // A fall is only counted behind a rise, so a free-running serial clock that
   // happens to be high at select cannot skew the bit count.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rise_cnt <= 4'h0;
         fall_cnt <= 4'h0;
         addr <= 8'h00;
      end else if (state != sam_pkg::SAM_DEV_XFER) begin
         rise_cnt <= 4'h0;
         fall_cnt <= 4'h0;
      end else begin
         if (sclk_rise && rise_cnt < 4'(sam_pkg::EXCHANGE_BITS)) begin
            addr <= {addr[6:0], sdi_s};
            rise_cnt <= rise_cnt + 4'h1;
         end
         if (sclk_fall && fall_cnt < rise_cnt) begin
            fall_cnt <= fall_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shift <= sam_pkg::RESULT_RESET;
      end else if (state != sam_pkg::SAM_DEV_XFER) begin
         shift <= result_ok ? result : sam_pkg::RESULT_RESET;
      end else if (sclk_fall && fall_cnt < rise_cnt) begin
         shift <= {shift[6:0], 1'b0};
      end
   end

   // Output drives from the synchronised select, ahead of the filter.
   assign link.sdo = shift[7];
   assign link.sdo_oe = ~cs_raw;

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         channel_code <= 5'h00;
         channel_kind <= sam_pkg::SAM_SEL_NONE;
      end else if (state == sam_pkg::SAM_DEV_XFER && sclk_rise
                   && rise_cnt == 4'(sam_pkg::CODE_BITS - 1)) begin
         channel_code <= {addr[3:0], sdi_s};
         if ({addr[3:0], sdi_s} >= sam_pkg::LOGIC_CODE_MIN) begin
            channel_kind <= sam_pkg::SAM_SEL_LOGIC;
         end else if ({addr[3:0], sdi_s} >= sam_pkg::NONE_CODE_MIN) begin
            channel_kind <= sam_pkg::SAM_SEL_NONE;
         end else if ({addr[3:0], sdi_s} == sam_pkg::TEST_CODE) begin
            channel_kind <= sam_pkg::SAM_SEL_TEST;
         end else begin
            channel_kind <= sam_pkg::SAM_SEL_ANALOG;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         test_out <= 5'h00;
         test_out_oe <= 5'h00;
      end else begin
         test_out <= result[4:0];
         test_out_oe <= (channel_kind == sam_pkg::SAM_SEL_LOGIC) ? 5'h1f : 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // The approximation needs eight rises after the hold; with the nominal clocks
   // that leaves ample margin, but a much faster conversion clock would cut it short.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         samp_cnt <= 9'h000;
         conv_cnt <= 6'h00;
      end else if (state != sam_pkg::SAM_DEV_CONV) begin
         samp_cnt <= 9'h000;
         conv_cnt <= 6'h00;
      end else begin
         if (samp_cnt < 9'(SAMPLE_CYCLES)) begin
            samp_cnt <= samp_cnt + 9'h001;
         end
         if (conv_rise) begin
            conv_cnt <= conv_cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         held <= 8'h00;
         approx <= 8'h00;
         mask <= 8'h00;
      end else if (capture) begin
         if (channel_kind == sam_pkg::SAM_SEL_TEST) begin
            held <= sam_pkg::TEST_LEVEL;
         end else if (channel_kind == sam_pkg::SAM_SEL_ANALOG) begin
            held <= analog_levels[int'(channel_code)*8 +: 8];
         end else begin
            held <= 8'h00;
         end
         approx <= 8'h00;
         mask <= 8'h80;
      end else if (state == sam_pkg::SAM_DEV_CONV && conv_rise && mask != 8'h00) begin
         approx <= (trial <= held) ? trial : approx;
         mask <= {1'b0, mask[7:1]};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         result <= sam_pkg::RESULT_RESET;
         result_ok <= 1'b0;
      end else if (conv_done) begin
         result <= approx;
         result_ok <= 1'b1;
      end else if ((state == sam_pkg::SAM_DEV_XFER && filt_rise)
                   || (state == sam_pkg::SAM_DEV_CONV && filt_fall)) begin
         result_ok <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sampling <= 1'b0;
         converting <= 1'b0;
         result_valid <= 1'b0;
      end else begin
         sampling <= (state == sam_pkg::SAM_DEV_XFER && rise_cnt >= 4'(sam_pkg::CODE_BITS))
                     || (state == sam_pkg::SAM_DEV_CONV && samp_cnt < 9'(SAMPLE_CYCLES));
         converting <= (state == sam_pkg::SAM_DEV_CONV);
         result_valid <= result_ok;
      end
   end

endmodule // sam_device

// [core/sam_pkg.sv]
/*
 Shared constants and types for the serial converter link: both ends and the FIFO.
 Assumes a 250 MHz system clock on both ends and a host-made conversion clock.
*/
package sam_pkg;
   localparam int CLOCK_PERIOD_NS = 4;
   localparam int CONV_PERIOD_NS = 480;
   localparam int SCLK_PERIOD_NS = 1920;
   localparam int SAMPLE_TIME_NS = 1000;
   localparam int SAMPLE_CYCLES = (SAMPLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int CONV_HALF_CYCLES = CONV_PERIOD_NS / (2 * CLOCK_PERIOD_NS);
   localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLOCK_PERIOD_NS);
   localparam int EXCHANGE_BITS = 8;
   localparam int CODE_BITS = 5;
   localparam int NUM_INPUTS = 19;
   localparam int CONV_MIN = 26;
   localparam int CONV_MAX = 32;
   localparam int CONV_CYCLES_DEF = 29;
   localparam int CS_FILTER_EDGES = 2;
   localparam int CS_STROBE_MIN = 4;
   localparam int SETUP_CONV_PERIODS = 4;
   localparam int SETUP_CYCLES = (SETUP_CONV_PERIODS + 1) * 2 * CONV_HALF_CYCLES
                                 + SCLK_HALF_CYCLES;
   localparam int CONV_WAIT_CYCLES = (CONV_MAX + CS_STROBE_MIN) * 2 * CONV_HALF_CYCLES;
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] TEST_CODE = 5'h13;
   localparam logic [4:0] NONE_CODE_MIN = 5'h14;
   localparam logic [4:0] LOGIC_CODE_MIN = 5'h18;
   localparam logic [7:0] TEST_LEVEL = 8'h80;
   localparam logic [3:0] SYNC_RESET = 4'h1;
   localparam logic [7:0] RESULT_RESET = 8'h00;

   typedef enum logic [1:0] {
      SAM_SEL_ANALOG = 2'b00,
      SAM_SEL_TEST = 2'b01,
      SAM_SEL_NONE = 2'b11,
      SAM_SEL_LOGIC = 2'b10
   } sam_sel_t;

   typedef enum logic [1:0] {
      SAM_DEV_IDLE = 2'b00,
      SAM_DEV_XFER = 2'b01,
      SAM_DEV_CONV = 2'b11
   } sam_dev_state_t;

   typedef enum logic [2:0] {
      SAM_HOST_IDLE = 3'b000,
      SAM_HOST_SETUP = 3'b001,
      SAM_HOST_SHIFT = 3'b011,
      SAM_HOST_WAIT = 3'b010,
      SAM_HOST_PUSH = 3'b110
   } sam_host_state_t;
endpackage

// [core/sam_if.sv]
/*
 Serial link between host and converter end.
 Assumes a pull-up holds the result line high while the converter does not drive it.
*/
`timescale 1ns/100ps
interface sam_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic conv_clk;
   logic sdo;
   logic sdo_oe;
   logic sdo_level;

   assign sdo_level = sdo_oe ? sdo : 1'b1;

   modport dev (
      input cs_n,
      input sclk,
      input sdi,
      input conv_clk,
      output sdo,
      output sdo_oe
   );

   modport host (
      output cs_n,
      output sclk,
      output sdi,
      output conv_clk,
      input sdo_level
   );
endinterface

// [core/sam_host.sv]
/*
 Host end: makes both link clocks, runs one exchange per command, buffers results.
 Assumes the converter end follows the link timing in the shared package.
*/
`timescale 1ns/100ps
module sam_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = sam_pkg::FIFO_DEPTH
) (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [PW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (PW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         end
         count <= count + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // sam_fifo

////////////////////////////////////////////////////////////////////////////////
module sam_host #(
   parameter int CONV_HALF = sam_pkg::CONV_HALF_CYCLES,
   parameter int SCLK_HALF = sam_pkg::SCLK_HALF_CYCLES,
   parameter int SETUP_CYCLES = (sam_pkg::SETUP_CONV_PERIODS + 1) * 2 * CONV_HALF + SCLK_HALF,
   parameter int CONV_WAIT_CYCLES = (sam_pkg::CONV_MAX + sam_pkg::CS_STROBE_MIN)
                                    * 2 * CONV_HALF,
   parameter int FIFO_DEPTH = sam_pkg::FIFO_DEPTH
) (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Link
   sam_if.host link,
   // Commands
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [4:0] cmd_channel,
   // Results
   output logic res_valid,
   input wire logic res_ready,
   output logic [7:0] res_data
);
   sam_pkg::sam_host_state_t state;
   logic [6:0] conv_div;
   logic conv_clk;
   logic [12:0] cnt;
   logic [2:0] bit_idx;
   logic [7:0] addr;
   logic [7:0] rx;
   logic sdo_a;
   logic sdo_s;
   logic cs_n;
   logic sclk;
   logic fifo_ready;

   assign cmd_ready = (state == sam_pkg::SAM_HOST_IDLE) && fifo_ready;
   assign link.cs_n = cs_n;
   assign link.sclk = sclk;
   assign link.sdi = addr[7];
   assign link.conv_clk = conv_clk;

   // Free-running so the converter never loses its sequencing clock.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         conv_div <= 7'h00;
         conv_clk <= 1'b0;
         sdo_a <= 1'b1;
         sdo_s <= 1'b1;
      end else begin
         sdo_a <= link.sdo_level;
         sdo_s <= sdo_a;
         if (conv_div == 7'(CONV_HALF - 1)) begin
            conv_div <= 7'h00;
            conv_clk <= ~conv_clk;
         end else begin
            conv_div <= conv_div + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Select rises in the same cycle as the eighth fall and stays high past the longest
   // conversion, which keeps every exchange aligned to a finished result.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= sam_pkg::SAM_HOST_IDLE;
         cnt <= 13'h0000;
         bit_idx <= 3'h0;
         addr <= 8'h00;
         rx <= 8'h00;
         cs_n <= 1'b1;
         sclk <= 1'b0;
      end else begin
         case (state)
            sam_pkg::SAM_HOST_IDLE: begin
               cnt <= 13'h0000;
               if (cmd_valid && fifo_ready) begin
                  addr <= {cmd_channel, 3'h0};
                  cs_n <= 1'b0;
                  state <= sam_pkg::SAM_HOST_SETUP;
               end
            end
            sam_pkg::SAM_HOST_SETUP: begin
               if (cnt == 13'(SETUP_CYCLES - 1)) begin
                  cnt <= 13'h0000;
                  bit_idx <= 3'h0;
                  state <= sam_pkg::SAM_HOST_SHIFT;
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            sam_pkg::SAM_HOST_SHIFT: begin
               if (cnt == 13'(SCLK_HALF - 1)) begin
                  cnt <= 13'h0000;
                  sclk <= ~sclk;
                  if (!sclk) begin
                     rx <= {rx[6:0], sdo_s};
                  end else begin
                     addr <= {addr[6:0], 1'b0};
                     bit_idx <= bit_idx + 3'h1;
                     if (bit_idx == 3'(sam_pkg::EXCHANGE_BITS - 1)) begin
                        cs_n <= 1'b1;
                        state <= sam_pkg::SAM_HOST_WAIT;
                     end
                  end
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            sam_pkg::SAM_HOST_WAIT: begin
               if (cnt == 13'(CONV_WAIT_CYCLES - 1)) begin
                  cnt <= 13'h0000;
                  state <= sam_pkg::SAM_HOST_PUSH;
               end else begin
                  cnt <= cnt + 13'h0001;
               end
            end
            sam_pkg::SAM_HOST_PUSH: begin
               if (fifo_ready) begin
                  state <= sam_pkg::SAM_HOST_IDLE;
               end
            end
            default: begin
               state <= sam_pkg::SAM_HOST_IDLE;
            end
         endcase
      end
   end

   sam_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clock(clock),
      .rst_n(rst_n),
      .in_valid(state == sam_pkg::SAM_HOST_PUSH),
      .in_ready(fifo_ready),
      .in_data(rx),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data(res_data)
   );
endmodule // sam_host

// [test/sam_properties.sv]
/* Concurrent checks on the link between host end and converter end.
   Assumes it is given the interface signals and the host divider values. */
`timescale 1ns/100ps
module sam_properties #(
   parameter int CONV_HALF = 4,
   parameter int SCLK_HALF = 8
) (
   // System
   input wire logic clock,
   input wire logic rst_n,
   // Link
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   input wire logic conv_clk,
   input wire logic sdo,
   input wire logic sdo_oe
);
   logic sclk_q;
   logic [3:0] rises;
   logic [15:0] low_cnt;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Rises and cycles are counted only while select is low.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sclk_q <= 1'b0;
         rises <= 4'h0;
         low_cnt <= 16'h0;
      end else begin
         sclk_q <= sclk;
         rises <= cs_n ? 4'h0 : rises + {3'h0, sclk & ~sclk_q};
         low_cnt <= cs_n ? 16'h0 : low_cnt + 16'h1;
      end
   end

   ////////////////////////////////////////////////////////////
   sequence s_select;
      $fell(cs_n);
   endsequence
   sequence s_release;
      $rose(cs_n);
   endsequence

   a_select_drive: assert property (s_select |-> ##[1:3] sdo_oe)
      else $error("result line not driven after select");
   a_release_float: assert property (s_release |-> ##[1:4] !sdo_oe)
      else $error("result line still driven after release");
   a_sdo_steady: assert property ($rose(sclk) |=> $stable(sdo) [*3])
      else $error("result bit moved while serial clock high");
   a_sdi_steady: assert property ($changed(sdi) |-> !sclk)
      else $error("address bit moved while serial clock high");
   a_eight_clocks: assert property (s_release |-> rises == 4'h8)
      else $error("exchange did not hold eight serial clocks");
   a_setup_time: assert property ($rose(sclk) && rises == 4'h0 |->
      low_cnt >= 16'(8 * CONV_HALF + SCLK_HALF))
      else $error("first serial clock rise before setup");
   a_conv_running: assert property ($rose(conv_clk) |-> ##CONV_HALF $fell(conv_clk))
      else $error("conversion clock stalled");
   a_sclk_parked: assert property (cs_n |-> !sclk)
      else $error("serial clock moving outside a frame");
endmodule // sam_properties

// [test/serial_adc_mux_interface_test.sv]
/* Bench: host and converter end joined, plus a bench-driven converter end.
   Assumes the shared package, interface and both design ends. */
`timescale 1ns/100ps
module serial_adc_mux_interface_test;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_ready;
   logic [4:0] cmd_channel = 5'h00;
   logic res_valid;
   logic res_ready = 1'b0;
   logic [7:0] res_data;
   logic [sam_pkg::NUM_INPUTS*8-1:0] levels;
   logic [4:0] code;
   sam_pkg::sam_sel_t kind;
   logic [4:0] oe_out;
   logic valid_b;
   logic conv_b;
   logic [4:0] tout;
   logic [7:0] prev;
   logic [7:0] rx;
   logic [4:0] chans [9] = '{5'h00, 5'h05, 5'h12, 5'h13, 5'h14, 5'h17, 5'h18, 5'h1f, 5'h03};
   int errors = 0;
   int n_compared = 0;
   int cycles = 0;
   sam_if link();
   sam_if link_b();

   sam_host #(.CONV_HALF(4), .SCLK_HALF(8))
      sam_host_inst (.clock(clock), .rst_n(rst_n), .link(link), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_channel(cmd_channel), .res_valid(res_valid),
      .res_ready(res_ready), .res_data(res_data));
   sam_device #(.SAMPLE_CYCLES(20)) sam_device_inst (.clock(clock), .rst_n(rst_n),
      .link(link), .analog_levels(levels), .channel_code(code), .channel_kind(kind),
      .sampling(), .converting(), .result_valid(), .test_out(tout), .test_out_oe(oe_out));
   sam_device #(.SAMPLE_CYCLES(20)) sam_device_inst_b (.clock(clock), .rst_n(rst_n),
      .link(link_b), .analog_levels(levels), .channel_code(), .channel_kind(),
      .sampling(), .converting(conv_b), .result_valid(valid_b), .test_out(), .test_out_oe());
   sam_properties sam_properties_inst (.clock(clock),
      .rst_n(rst_n), .cs_n(link.cs_n), .sclk(link.sclk), .sdi(link.sdi),
      .conv_clk(link.conv_clk), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

   always #2 clock = ~clock;
   always #12 link_b.conv_clk = ~link_b.conv_clk;

   ////////////////////////////////////////////////////////////
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   function automatic logic [7:0] expect_of(input logic [4:0] ch);
      if (ch < 5'h13) return levels[int'(ch)*8 +: 8];
      return (ch == sam_pkg::TEST_CODE) ? sam_pkg::TEST_LEVEL : 8'h00;
   endfunction

   function automatic sam_pkg::sam_sel_t kind_of(input logic [4:0] ch);
      if (ch < 5'h13) return sam_pkg::SAM_SEL_ANALOG;
      if (ch == 5'h13) return sam_pkg::SAM_SEL_TEST;
      return (ch < 5'h18) ? sam_pkg::SAM_SEL_NONE : sam_pkg::SAM_SEL_LOGIC;
   endfunction

   task automatic issue(input logic [4:0] ch);
      step(1);
      cmd_channel = ch;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) step(1);
      step(1);
      cmd_valid = 1'b0;
   endtask

   task automatic pop(input logic [7:0] exp);
      step(1);
      while (res_valid !== 1'b1) step(1);
      check(res_data, exp);
      res_ready = 1'b1;
      step(1);
      res_ready = 1'b0;
   endtask

   // Bench-driven exchange; fewer than eight bits ends in an abort.
   task automatic bang(input logic [7:0] addr, input int bits);
      link_b.cs_n = 1'b0;
      step(80);
      for (int i = 7; i > 7 - bits; i--) begin
         link_b.sdi = addr[i];
         step(16);
         rx[i] = link_b.sdo_level;
         link_b.sclk = 1'b1;
         step(16);
         link_b.sclk = 1'b0;
      end
      step(8);
      link_b.cs_n = 1'b1;
      link_b.sdi = ~link_b.sdi;
      step(100);
   endtask

   always @(posedge clock) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////
   initial begin
      link_b.cs_n = 1'b1;
      link_b.sclk = 1'b0;
      link_b.sdi = 1'b0;
      link_b.conv_clk = 1'b0;
      rx = 8'h00;
      for (int n = 0; n < sam_pkg::NUM_INPUTS; n++) levels[n*8 +: 8] = 8'(n * 13 + 33);
      step(16);
      rst_n = 1'b1;
      prev = 8'h00;
      foreach (chans[k]) begin
         issue(chans[k]);
         pop(prev);
         check({3'h0, code}, {3'h0, chans[k]});
         check({6'h0, kind}, {6'h0, kind_of(chans[k])});
         check({3'h0, oe_out}, (chans[k] >= 5'h18) ? 8'h1f : 8'h00);
         check({3'h0, tout}, expect_of(chans[k]) & 8'h1f);
         prev = expect_of(chans[k]);
      end
      $display("test of channel codes done");
      for (int k = 0; k < 16; k++) issue(5'(k));
      step(500);
      check({7'h0, cmd_ready}, 8'h00);
      for (int k = 0; k < 16; k++) begin
         pop(prev);
         prev = expect_of(5'(k));
      end
      check({7'h0, res_valid}, 8'h00);
      $display("test of buffer fill and drain done");
      bang({5'h09, 3'h5}, 8);
      check(rx, 8'h00);
      check({7'h0, conv_b}, 8'h01);
      step(400);
      check({7'h0, conv_b}, 8'h00);
      check({7'h0, valid_b}, 8'h01);
      check({7'h0, link_b.sdo_level}, 8'h01);
      bang(8'h00, 3);
      check(rx & 8'he0, expect_of(5'h09) & 8'he0);
      check({7'h0, valid_b}, 8'h00);
      bang({5'h02, 3'h0}, 8);
      check(rx, 8'h00);
      step(400);
      bang(8'h00, 8);
      check(rx, expect_of(5'h02));
      $display("test of abort and recovery done");
      conclude();
   end
endmodule // serial_adc_mux_interface_test
